// file: tcei_params.svh
`ifndef TCEI_PARAMS_SVH
`define TCEI_PARAMS_SVH

// Register byte offsets
`define TCEI_OFF_CTRL_LOAD  12'h000
`define TCEI_OFF_CTRL_XOR   12'h004
`define TCEI_OFF_STATUS     12'h008
`define TCEI_OFF_WC         12'h00c
`define TCEI_OFF_TM_WORD    12'h010
`define TCEI_OFF_DTF_CLEAR  12'h014

// Field widths and reset values
`define TCEI_CTRL_W         10
`define TCEI_STAT_W         7
`define TCEI_WORD_W         18
`define TCEI_MARK_BITS      6
`define TCEI_MARK_STRIDE    3
`define TCEI_CTRL_RST       10'h000
`define TCEI_STAT_RST       7'h00
`define TCEI_WC_RST         18'h00000

// Timing: clock rate, select delay, timing track bit cell
`define TCEI_CLK_MHZ        250
`define TCEI_SEL_DELAY_MS   120
`define TCEI_BIT_TIME_NS    33333

`endif

// file: tcei_pkg.sv
package tcei_pkg;

  // Tape functions held in the control register
  typedef enum logic [2:0] {
    TCEI_FN_MOVE       = 3'b000,
    TCEI_FN_SEARCH     = 3'b001,
    TCEI_FN_READ_DATA  = 3'b010,
    TCEI_FN_READ_ALL   = 3'b011,
    TCEI_FN_WRITE_DATA = 3'b100,
    TCEI_FN_WRITE_ALL  = 3'b101,
    TCEI_FN_TM_WRITE   = 3'b110,
    TCEI_FN_UNUSED     = 3'b111
  } tcei_fn_t;

  // First status (control) word, bit 9 down to bit 0
  typedef struct packed {
    logic       int_enable;   // Bit 9: flags reach the interrupt
    logic [2:0] unit;         // Selected transport
    logic       run_on_mode;  // 1 = run-on, 0 = per-block mode
    logic       motion;       // Motion bit
    logic       reverse;      // Direction
    tcei_fn_t   fn;           // Function code
  } tcei_ctrl_t;

  // Second status word: flags and error bits
  typedef struct packed {
    logic transfer_done_flag;  // Bit 6
    logic error_flag_out;      // Bit 5
    logic timing_err;          // Bit 4
    logic parity_err;          // Bit 3
    logic tape_end_zone_error; // Bit 2
    logic select_err;          // Bit 1
    logic mark_err;            // Bit 0
  } tcei_stat_t;

  // Conditions reported by the selected transport and panel
  typedef struct packed {
    logic word_strobe;     // One pulse per data word passing the head
    logic block_end;       // One pulse at the end of a data block
    logic mark_ok;         // Legitimate mark seen with word_strobe
    logic bcc_match;       // Block check matched, with block_end
    logic data_area;       // Head is over a data area
    logic end_zone;        // Tape is inside an end zone
    logic offline;         // Selected unit off-line
    logic dup_unit;        // Two transports answer the same number
    logic write_locked;    // Selected unit is write locked
  } tcei_tape_in_t;

  // Commands to the selected transport
  typedef struct packed {
    logic       motion;       // Transport running
    logic       reverse;      // Direction
    logic [2:0] unit;         // Unit number
    logic       write_enable; // Writers on
    logic       timing_track; // Timing track write level
    logic       mark_track;   // Mark track write level
  } tcei_tape_out_t;

endpackage

// file: tcei_mark_ser.sv
`timescale 1ns/1ps
`include "tcei_params.svh"

// Timing and mark track recorder, one bit cell per divider enable
module tcei_mark_ser
  import tcei_pkg::*;
#(
  parameter int unsigned BIT_CYC = 8333
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Control
  input  wire logic                     run,
  input  wire logic [`TCEI_WORD_W-1:0]  word,
  // Track levels and word pacing
  output logic                          timing_track,
  output logic                          mark_track,
  output logic                          word_done
);

  localparam int DW = $clog2(BIT_CYC + 1);

  typedef struct packed {
    logic [DW-1:0]               div;    // Bit cell divider
    logic [2:0]                  bit_no; // Bit within the word
    logic [`TCEI_MARK_BITS-1:0]  sh;     // Mark bits still to record
    logic                        tt;     // Timing track level
    logic                        mk;     // Mark track level
    logic                        done;   // Word finished pulse
  } tcei_ser_t;

  tcei_ser_t st;
  tcei_ser_t next_st;
  logic [`TCEI_MARK_BITS-1:0] picked;   // Mark bits taken from the word

  // Mark value comes from every third bit of the word
  for (genvar i = 0; i < `TCEI_MARK_BITS; i++) begin : g_pick
    assign picked[i] = word[i*`TCEI_MARK_STRIDE];
  end

  // Divider, timing track toggle and mark shift
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (!run) begin
      next_st.div    = '0;
      next_st.bit_no = '0;
      next_st.tt     = 1'b0;
      next_st.mk     = 1'b0;
    end else if (st.div == DW'(BIT_CYC - 1)) begin
      next_st.div = '0;
      next_st.tt  = ~st.tt;
      if (st.bit_no == 3'h0) begin
        next_st.sh = picked;
      end
      next_st.mk = (st.bit_no == 3'h0) ? picked[0] : st.sh[st.bit_no];
      if (st.bit_no == 3'(`TCEI_MARK_BITS - 1)) begin
        next_st.bit_no = '0;
        next_st.done   = 1'b1;
      end else begin
        next_st.bit_no = st.bit_no + 3'h1;
      end
    end else begin
      next_st.div = st.div + DW'(1);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign timing_track = st.tt;
  assign mark_track   = st.mk;
  assign word_done    = st.done;

endmodule // tcei_mark_ser

// file: tcei_ctrl.sv
`timescale 1ns/1ps
`include "tcei_params.svh"

// Functional notes
// - Timing-mark write only in maintenance position
// - Mark bits come from bits 0,3,...,15
// - Per-block flags each word, each block end in data functions; run-on at overflow
// - Per-block overflow, flag uncleared gives timing error
// - Run-on after overflow records zeros while moving
// - Bit 9 gates flag and errors to interrupt
// - Bit 9 never changes status bits or skip
// - Each error sets flag, own bit, interrupt
// - Error skip is OR of error bits
// - Non-parity errors stop transport, no transfer flag
// - Per-block parity: motion kept, flags together
// - Run-on parity: flag at block end, continues
// - Timing error on missed word or data switch
// - Parity only in read data, check mismatch
// - Select error cases, including function seven
// - End zone stops transfer, flags, stops, interrupts
// - Mark error outside move and timing-mark write
// - Clear-and-load starts select delay; XOR does not
// - End zone reported in status bit 2
// - Word counter counts up, overflow marks last
module tcei_ctrl
  import tcei_pkg::*;
#(
  parameter int unsigned SEL_DELAY_CYC =
    `TCEI_SEL_DELAY_MS * `TCEI_CLK_MHZ * 1000,
  parameter int unsigned BIT_CYC = `TCEI_BIT_TIME_NS * `TCEI_CLK_MHZ / 1000
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Transport side
  input  tcei_tape_in_t      tape_in,
  input  wire logic          timing_mark_write_position,
  output tcei_tape_out_t     tape_out,
  // Processor side flags
  output logic               irq,
  output logic               error_skip_test
);

  localparam int DLW = $clog2(SEL_DELAY_CYC + 1);

  // Whole block state
  typedef struct packed {
    tcei_ctrl_t              ctrl;       // First status word
    tcei_stat_t              stat;       // Second status word
    logic [`TCEI_WORD_W-1:0] word_counter;
    logic                    counter_overflow;
    logic [`TCEI_WORD_W-1:0] tm_word;    // Word for timing-mark write
    logic [DLW-1:0]          sel_delay;  // Unit select delay count
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic                    irq;
    logic                    skip;
    logic                    motion_o;
    logic                    wen_o;
  } tcei_state_t;

  tcei_state_t st;
  tcei_state_t next_st;

  logic ser_run;        // Timing-mark write engine running
  logic ser_tt;         // Timing track level from the engine
  logic ser_mk;         // Mark track level from the engine
  logic ser_word_done;  // Engine finished one word
  logic [`TCEI_WORD_W-1:0] ser_word; // Word fed to the engine

  // Mark track and timing track recorder
  tcei_mark_ser #(
    .BIT_CYC (BIT_CYC)
  ) u_mark_ser (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          (ser_run),
    .word         (ser_word),
    .timing_track (ser_tt),
    .mark_track   (ser_mk),
    .word_done    (ser_word_done)
  );

  // Engine runs only in the maintenance position
  assign ser_run = (st.ctrl.fn == TCEI_FN_TM_WRITE) && st.ctrl.motion
                   && (st.sel_delay == '0)
                   && timing_mark_write_position;
  // After overflow in run-on mode only zeros are recorded
  assign ser_word = (st.counter_overflow && st.ctrl.run_on_mode) ?
                    '0 : st.tm_word;

  // Next-state logic
  always_comb begin
    logic        setup;      // APB setup cycle
    logic        wr;         // Write taking effect
    logic        mapped;     // Address hits a register
    logic        load;       // Clear-and-load of the control word
    logic        xupd;       // XOR update of the control word
    logic        active;     // Transport may transfer
    logic        word_evt;   // A word time of the current function
    logic        per_word;   // Function flags per word
    logic [4:0]  err_set;    // Errors raised this cycle
    logic        dtf_set;    // Transfer flag raised this cycle
    logic        stop;       // Stop the transport
    logic [`TCEI_STAT_W-1:0] clr; // Status bits cleared by software
    logic [`TCEI_WORD_W-1:0] wc_inc; // Counter plus one
    tcei_ctrl_t  nc;         // Control word after a write
    next_st  = st;
    setup    = psel && !penable;
    wr       = psel && penable && st.pready && pwrite;
    mapped   = (paddr == `TCEI_OFF_CTRL_LOAD) ||
               (paddr == `TCEI_OFF_CTRL_XOR) ||
               (paddr == `TCEI_OFF_STATUS) ||
               (paddr == `TCEI_OFF_WC) ||
               (paddr == `TCEI_OFF_TM_WORD) ||
               (paddr == `TCEI_OFF_DTF_CLEAR);
    load     = wr && (paddr == `TCEI_OFF_CTRL_LOAD);
    xupd     = wr && (paddr == `TCEI_OFF_CTRL_XOR);
    err_set  = '0;
    dtf_set  = 1'b0;
    stop     = 1'b0;
    clr      = '0;
    wc_inc   = st.word_counter + `TCEI_WORD_W'(1);
    nc       = st.ctrl;
    active   = st.ctrl.motion && (st.sel_delay == '0);
    per_word = (st.ctrl.fn == TCEI_FN_READ_ALL) ||
               (st.ctrl.fn == TCEI_FN_WRITE_ALL) ||
               (st.ctrl.fn == TCEI_FN_TM_WRITE);
    word_evt = (st.ctrl.fn == TCEI_FN_TM_WRITE) ? ser_word_done
                                                 : tape_in.word_strobe;

    // APB answer one cycle after setup; unmapped address errors
    next_st.pready  = setup;
    next_st.pslverr = setup && !mapped;
    if (setup) begin
      case (paddr)
        `TCEI_OFF_CTRL_LOAD,
        `TCEI_OFF_CTRL_XOR: next_st.prdata = 32'(st.ctrl);
        `TCEI_OFF_STATUS:   next_st.prdata = 32'(st.stat);
        `TCEI_OFF_WC:       next_st.prdata = 32'(st.word_counter);
        `TCEI_OFF_TM_WORD:  next_st.prdata = 32'(st.tm_word);
        default:            next_st.prdata = 32'h0000_0000;
      endcase
    end

    // Select delay counts down; only clear-and-load restarts it
    if (st.sel_delay != '0) begin
      next_st.sel_delay = st.sel_delay - DLW'(1);
    end

    // Control word writes and checks at function start
    if (load || xupd) begin
      if (load) begin
        nc = tcei_ctrl_t'(pwdata[`TCEI_CTRL_W-1:0]);
        next_st.sel_delay = DLW'(SEL_DELAY_CYC);
      end else begin
        nc = tcei_ctrl_t'(st.ctrl ^ pwdata[`TCEI_CTRL_W-1:0]);
      end
      if (nc.motion) begin
        if (tape_in.dup_unit || tape_in.offline ||
            (nc.fn == TCEI_FN_UNUSED) ||
            (((nc.fn == TCEI_FN_WRITE_DATA) ||
              (nc.fn == TCEI_FN_WRITE_ALL) ||
              (nc.fn == TCEI_FN_TM_WRITE)) && tape_in.write_locked) ||
            ((nc.fn == TCEI_FN_TM_WRITE) !=
             timing_mark_write_position)) begin
          err_set[1] = 1'b1;
        end
        if ((nc.fn != st.ctrl.fn) && tape_in.data_area &&
            ((nc.fn == TCEI_FN_READ_DATA) ||
             (nc.fn == TCEI_FN_WRITE_DATA))) begin
          err_set[4] = 1'b1;
        end
      end
      next_st.ctrl = nc;
    end

    // Word times: counter, per-word flags, missed words, marks
    if (word_evt && active && (st.ctrl.fn != TCEI_FN_MOVE)) begin
      if ((st.ctrl.fn != TCEI_FN_TM_WRITE) && !tape_in.mark_ok) begin
        err_set[0] = 1'b1;
      end else if (per_word && !st.ctrl.run_on_mode &&
                   st.stat.transfer_done_flag) begin
        err_set[4] = 1'b1;
      end else if (!st.counter_overflow &&
                   (st.ctrl.fn != TCEI_FN_SEARCH)) begin
        next_st.word_counter = wc_inc;
        if (wc_inc == '0) begin
          next_st.counter_overflow = 1'b1;
        end
        if (per_word && (!st.ctrl.run_on_mode || (wc_inc == '0))) begin
          dtf_set = 1'b1;
        end
      end
    end

    // Block ends of the data functions: parity and block flags
    if (tape_in.block_end && active &&
        ((st.ctrl.fn == TCEI_FN_READ_DATA) ||
         (st.ctrl.fn == TCEI_FN_WRITE_DATA))) begin
      if (!st.ctrl.run_on_mode && st.stat.transfer_done_flag) begin
        err_set[4] = 1'b1;
      end else begin
        if ((st.ctrl.fn == TCEI_FN_READ_DATA) && !tape_in.bcc_match) begin
          err_set[3] = 1'b1;
        end
        if (!st.ctrl.run_on_mode || st.counter_overflow) begin
          dtf_set = 1'b1;
        end
      end
    end

    // Inside an end zone while running, in either direction
    if (tape_in.end_zone && active) begin
      err_set[2] = 1'b1;
    end

    // Unit dropping off-line while running
    if (active && tape_in.offline) begin
      err_set[1] = 1'b1;
    end

    // Every error but parity stops the transport with no flag
    stop = |{err_set[4], err_set[2:0]};
    if (stop) begin
      next_st.ctrl.motion = 1'b0;
      dtf_set = 1'b0;
    end

    // Software clears
    if (wr && (paddr == `TCEI_OFF_STATUS)) begin
      clr = pwdata[`TCEI_STAT_W-1:0];
    end
    if (wr && (paddr == `TCEI_OFF_DTF_CLEAR)) begin
      clr[`TCEI_STAT_W-1] = 1'b1;
    end
    if (wr && (paddr == `TCEI_OFF_WC)) begin
      next_st.word_counter     = pwdata[`TCEI_WORD_W-1:0];
      next_st.counter_overflow = 1'b0;
    end
    if (wr && (paddr == `TCEI_OFF_TM_WORD)) begin
      next_st.tm_word = pwdata[`TCEI_WORD_W-1:0];
    end

    // Sticky status: a set in the same cycle beats a clear
    next_st.stat = tcei_stat_t'((st.stat & ~clr) |
                   {dtf_set, |err_set, err_set});

    // Interrupt gated by bit 9; status and skip are not
    next_st.irq  = next_st.ctrl.int_enable &&
                   (next_st.stat.transfer_done_flag ||
                    next_st.stat.error_flag_out);
    next_st.skip = |next_st.stat[4:0];

    // Transport drive
    next_st.motion_o = next_st.ctrl.motion &&
                       (next_st.sel_delay == '0);
    next_st.wen_o    = next_st.motion_o &&
                       ((next_st.ctrl.fn == TCEI_FN_TM_WRITE) ||
                        (((next_st.ctrl.fn == TCEI_FN_WRITE_DATA) ||
                          (next_st.ctrl.fn == TCEI_FN_WRITE_ALL)) &&
                         !next_st.counter_overflow));
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st              <= '0;
      st.ctrl         <= tcei_ctrl_t'(`TCEI_CTRL_RST);
      st.stat         <= tcei_stat_t'(`TCEI_STAT_RST);
      st.word_counter <= `TCEI_WC_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register; track levels from the engine's register
  assign pready                = st.pready;
  assign pslverr               = st.pslverr;
  assign prdata                = st.prdata;
  assign irq                   = st.irq;
  assign error_skip_test       = st.skip;
  assign tape_out.motion       = st.motion_o;
  assign tape_out.reverse      = st.ctrl.reverse;
  assign tape_out.unit         = st.ctrl.unit;
  assign tape_out.write_enable = st.wen_o;
  assign tape_out.timing_track = ser_tt;
  assign tape_out.mark_track   = ser_mk;

endmodule // tcei_ctrl

// file: tcei_ctrl_props.sv
`timescale 1ns/1ps
`include "tcei_params.svh"

// Port checker with APB write shadows
module tcei_ctrl_props
  import tcei_pkg::*;
#(
  parameter int unsigned SEL_DELAY_CYC = 8,
  parameter int unsigned BIT_CYC       = 4
) (
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // APB
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  input  wire logic           pready,
  input  wire logic [31:0]    prdata,
  input  wire logic           pslverr,
  // Transport side and flags
  input  tcei_tape_in_t       tape_in,
  input  wire logic           timing_mark_write_position,
  input  tcei_tape_out_t      tape_out,
  input  wire logic           irq,
  input  wire logic           error_skip_test
);
  logic        wr_acc;  // Write taken at this edge
  logic        ctl_en;  // Shadow of the interrupt enable bit
  logic [31:0] sel_cnt; // Cycles since the last clear-and-load, held at SEL_DELAY_CYC
  logic        sel_ok;  // Select delay surely counted out
  logic        ez_hit;  // End zone met while running
  assign wr_acc = psel && penable && pready && pwrite;
  assign sel_ok = sel_cnt >= SEL_DELAY_CYC;
  assign ez_hit = tape_in.end_zone && tape_out.motion && sel_ok && !wr_acc;
  // Shadow registers follow accepted writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_en  <= 1'b0;
      sel_cnt <= '0;
    end else if (wr_acc && paddr == `TCEI_OFF_CTRL_LOAD) begin
      ctl_en  <= pwdata[9];
      sel_cnt <= '0;
    end else begin
      ctl_en  <= ctl_en ^
                 (wr_acc && paddr == `TCEI_OFF_CTRL_XOR && pwdata[9]);
      sel_cnt <= sel_ok ? sel_cnt : sel_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_irq_gated: assert property (irq |-> ctl_en || $past(ctl_en))
    else $error("irq while enable bit clear");
  a_skip_holds: assert property (error_skip_test && !wr_acc |=> error_skip_test)
    else $error("error bits dropped without a write");
  a_end_zone_stop: assert property (ez_hit |=> !tape_out.motion && error_skip_test)
    else $error("end zone did not stop and flag");
  a_end_zone_irq: assert property (ez_hit && ctl_en |=> irq)
    else $error("end zone error gave no irq");
  a_fn_unused_sel: assert property (wr_acc && paddr == `TCEI_OFF_CTRL_LOAD
    && pwdata[4] && pwdata[2:0] == 3'h7 |-> ##[1:16] error_skip_test)
    else $error("unused function gave no select error");
  a_timing_track_pos: assert property ($changed(tape_out.timing_track)
    |-> timing_mark_write_position || $past(timing_mark_write_position))
    else $error("timing track written outside maintenance position");
  c_irq: cover property ($rose(irq));
  c_end_zone: cover property (ez_hit);
  c_slverr: cover property (pslverr);
endmodule // tcei_ctrl_props

// file: tcei_tape_model.sv
`timescale 1ns/1ps

// Transport model
module tcei_tape_model
  import tcei_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Controller commands and bench knobs
  input  tcei_tape_out_t  tape_out,
  input  wire logic [4:0] fault,     // Zone, offline, dup, locked, area
  input  wire logic       mark_good, // Marks readable
  input  wire logic       bcc_good,  // Block check matches
  // Transport status and mark track monitor
  output tcei_tape_in_t   tape_in,
  output int              mark_hi    // Cycles with mark track high
);
  logic [2:0] ph;     // Cycle within a word
  logic [1:0] wn;     // Word within a block
  logic       strobe; // Word pulse
  logic       blk;    // Block end pulse
  // Word every 5 cycles, block end between words after every fourth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph      <= 3'h0;
      wn      <= 2'h0;
      strobe  <= 1'b0;
      blk     <= 1'b0;
      mark_hi <= 0;
    end else begin
      ph      <= (!tape_out.motion || ph == 3'h4) ? 3'h0 : ph + 3'h1;
      strobe  <= tape_out.motion && ph == 3'h4;
      blk     <= tape_out.motion && ph == 3'h2 && wn == 2'h3;
      wn      <= wn + 2'(strobe);
      mark_hi <= mark_hi + int'(tape_out.mark_track);
    end
  end
  // Levels as the selected transport reports them
  always_comb begin
    tape_in              = '0;
    tape_in.word_strobe  = strobe;
    tape_in.block_end    = blk;
    tape_in.mark_ok      = mark_good;
    tape_in.bcc_match    = bcc_good;
    tape_in.end_zone     = fault[4];
    tape_in.offline      = fault[3];
    tape_in.dup_unit     = fault[2];
    tape_in.write_locked = fault[1];
    tape_in.data_area    = fault[0];
  end
endmodule // tcei_tape_model

// file: tb.sv
`timescale 1ns/1ps
`include "tcei_params.svh"

module tb;
  import tcei_pkg::*;
  localparam int SEL = 8;        // Shortened select delay
  localparam int BITC = 4;       // Shortened bit cell
  localparam int W = 6 * BITC;   // Cycles per timing-mark word
  localparam logic [11:0] LD = `TCEI_OFF_CTRL_LOAD;
  localparam logic [11:0] XR = `TCEI_OFF_CTRL_XOR;
  localparam logic [11:0] ST = `TCEI_OFF_STATUS;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic           tmpos, irq, skip, er, mark_good, bcc_good;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rd, seed, v, x;
  logic [4:0]     fault;
  logic [13:0]    tab [6];       // Fault, position and control per case
  tcei_tape_in_t  tape_in;
  tcei_tape_out_t tape_out;
  int             mark_hi, m0, t, i, error_cnt, n_tests;

  // Clock
  always #2 pclk = ~pclk;

  tcei_ctrl #(.SEL_DELAY_CYC(SEL), .BIT_CYC(BITC)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tape_in(tape_in), .timing_mark_write_position(tmpos),
    .tape_out(tape_out), .irq(irq), .error_skip_test(skip));
  tcei_tape_model u_tape (.pclk(pclk), .presetn(presetn),
    .tape_out(tape_out), .fault(fault), .mark_good(mark_good),
    .bcc_good(bcc_good), .tape_in(tape_in), .mark_hi(mark_hi));

  // Verdict and end of run
  task automatic complete_run;
    $display("mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) error_cnt++;
    @(posedge pclk);
  endtask
  // Read and compare
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                      input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  // Stop and clear
  task automatic stop;
    fault <= 5'h00;
    apb(1'b1, LD, 32'h0);
    apb(1'b1, ST, 32'h7f);
  endtask
  // Xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Wait for irq
  task automatic wait_irq;
    t = 0;
    while (irq !== 1'b1 && t < 400) begin
      @(posedge pclk);
      t++;
    end
  endtask

  // Watchdog
  initial begin
    #80000;
    error_cnt++;
    complete_run;
  end

  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, tmpos, fault} = '0;
    {paddr, pwdata, error_cnt, n_tests} = '0;
    {mark_good, bcc_good} = 2'b11;
    seed = 32'h7a7f0e5c;
    tab = '{14'h0017, 14'h0810, 14'h0410, 14'h0214, 14'h0016, 14'h2010};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(LD, 32'h0, "control reset");
    rchk(ST, 32'h0, "status reset");
    apb(1'b0, 12'h020, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
    for (i = 0; i < 6; i++) begin
      v = xs() & 32'h3ef;
      x = xs() & 32'h3ef;
      apb(1'b1, LD, v);
      rchk(LD, v, "load readback");
      apb(1'b1, XR, x);
      rchk(LD, v ^ x, "xor readback");
    end
    stop();
    for (i = 0; i < 2; i++) begin
      fault <= 5'h10;
      apb(1'b1, LD, i ? 32'h210 : 32'h010);
      chk(32'(skip), 32'h0, "select delay after load");
      repeat (SEL + 4) @(posedge pclk);
      chk(32'(irq), 32'(i), "end zone irq");
      chk(32'(tape_out.motion), 32'h0, "end zone stop");
      fault <= 5'h00;
      rchk(ST, 32'h24, "end zone status");
      stop();
    end
    repeat (SEL + 4) @(posedge pclk);
    fault <= 5'h10;
    apb(1'b1, XR, 32'h010);
    repeat (2) @(posedge pclk);
    chk(32'(skip), 32'h1, "xor starts no delay");
    stop();
    for (i = 0; i < 6; i++) begin
      fault <= tab[i][12:8];
      tmpos <= tab[i][13];
      apb(1'b1, LD, {24'h0, tab[i][7:0]});
      repeat (SEL + 4) @(posedge pclk);
      chk(32'(tape_out.motion), 32'h0, "select stop");
      rchk(ST, 32'h22, "select error");
      tmpos <= 1'b0;
      stop();
    end
    mark_good <= 1'b0;
    apb(1'b1, LD, 32'h012);
    repeat (SEL + 12) @(posedge pclk);
    rchk(ST, 32'h21, "mark error");
    stop();
    apb(1'b1, LD, 32'h010);
    repeat (SEL + 12) @(posedge pclk);
    rchk(ST, 32'h0, "no mark check in move");
    stop();
    mark_good <= 1'b1;
    bcc_good <= 1'b0;
    for (i = 0; i < 2; i++) begin
      apb(1'b1, LD, i ? 32'h032 : 32'h012);
      t = 0;
      do begin
        apb(1'b0, ST, 32'h0);
        t++;
      end while (rd[5] !== 1'b1 && t < 40);
      chk(rd, i ? 32'h28 : 32'h68, "parity flags");
      chk(32'(tape_out.motion), 32'h1, "parity keeps motion");
      stop();
    end
    apb(1'b1, LD, 32'h013);
    repeat (60) @(posedge pclk);
    rchk(ST, 32'h70, "no parity in read all");
    stop();
    bcc_good <= 1'b1;
    tmpos <= 1'b1;
    apb(1'b1, `TCEI_OFF_WC, 32'h3fffd);
    apb(1'b1, `TCEI_OFF_TM_WORD, 32'h36db6);
    m0 = mark_hi;
    apb(1'b1, LD, 32'h236);
    wait_irq();
    chk(32'(t > 2 * W && t < 5 * W), 32'h1, "run-on irq at overflow");
    chk(mark_hi - m0, 32'h0, "mark bits only");
    apb(1'b1, `TCEI_OFF_DTF_CLEAR, 32'h0);
    apb(1'b1, `TCEI_OFF_TM_WORD, 32'h3ffff);
    m0 = mark_hi;
    repeat (2 * W) @(posedge pclk);
    chk(mark_hi - m0, 32'h0, "zeros after overflow");
    stop();
    apb(1'b1, `TCEI_OFF_WC, 32'h3ffff);
    apb(1'b1, `TCEI_OFF_TM_WORD, 32'h09249);
    m0 = mark_hi;
    apb(1'b1, LD, 32'h216);
    wait_irq();
    chk(32'(t < 2 * W + SEL), 32'h1, "per-block irq per word");
    chk(32'(mark_hi > m0), 32'h1, "mark bits written");
    repeat (3 * W) @(posedge pclk);
    rchk(ST, 32'h70, "flag left set");
    stop();
    complete_run();
  end
endmodule // tb

bind tcei_ctrl tcei_ctrl_props #(.SEL_DELAY_CYC(SEL_DELAY_CYC),
  .BIT_CYC(BIT_CYC)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .tape_in(tape_in),
  .timing_mark_write_position(timing_mark_write_position),
  .tape_out(tape_out), .irq(irq), .error_skip_test(error_skip_test));
